// >>> hdl/ftc_pkg.sv
// Package: constants for the fault-tolerant CAN physical control block.
package ftc_pkg;
  // ==========================================================================
  // Time base
  // ==========================================================================
  localparam int unsigned CLK_MHZ = 50;
  // ==========================================================================
  // Times in microseconds, as printed (tenths where needed)
  // ==========================================================================
  localparam int unsigned T_WAKE_US = 16;
  localparam int unsigned T_DF3_US = 30;
  localparam int unsigned T_DR3_US = 160;
  localparam int unsigned T_DF6_US = 200;
  localparam int unsigned T_DR6_US = 200;
  localparam int unsigned T_DF47_US = 1500;
  localparam int unsigned T_DR47_US = 30;
  localparam int unsigned T_DF8_US = 1700;
  localparam int unsigned T_DR8_US = 1500;
  localparam int unsigned T_DF47_BAT_US = 1200;
  localparam int unsigned T_DR47_BAT_US = 1920;
  localparam int unsigned T_DF3_BAT_US = 3840;
  localparam int unsigned T_DR3_BAT_US = 1920;
  localparam int unsigned T_DF8_BAT_US = 2300;
  localparam int unsigned T_DR8_BAT_US = 1200;
  localparam int unsigned T_TXD_US = 2000;
  localparam int unsigned T_TXE_US = 30;
  // ==========================================================================
  // Cycle counts
  // ==========================================================================
  localparam int unsigned C_WAKE = T_WAKE_US * CLK_MHZ;
  localparam int unsigned C_DF3 = T_DF3_US * CLK_MHZ;
  localparam int unsigned C_DR3 = T_DR3_US * CLK_MHZ;
  localparam int unsigned C_DF6 = T_DF6_US * CLK_MHZ;
  localparam int unsigned C_DR6 = T_DR6_US * CLK_MHZ;
  localparam int unsigned C_DF47 = T_DF47_US * CLK_MHZ;
  localparam int unsigned C_DR47 = T_DR47_US * CLK_MHZ;
  localparam int unsigned C_DF8 = T_DF8_US * CLK_MHZ;
  localparam int unsigned C_DR8 = T_DR8_US * CLK_MHZ;
  localparam int unsigned C_DF47_BAT = T_DF47_BAT_US * CLK_MHZ;
  localparam int unsigned C_DR47_BAT = T_DR47_BAT_US * CLK_MHZ;
  localparam int unsigned C_DF3_BAT = T_DF3_BAT_US * CLK_MHZ;
  localparam int unsigned C_DR3_BAT = T_DR3_BAT_US * CLK_MHZ;
  localparam int unsigned C_DF8_BAT = T_DF8_BAT_US * CLK_MHZ;
  localparam int unsigned C_DR8_BAT = T_DR8_BAT_US * CLK_MHZ;
  localparam int unsigned C_TXD = T_TXD_US * CLK_MHZ;
  localparam int unsigned C_TXE = T_TXE_US * CLK_MHZ;
  // ==========================================================================
  // Edge counting and widths
  // ==========================================================================
  localparam int unsigned EDGE_DIFF = 3;
  localparam int unsigned TMR_W = 18;
  localparam int unsigned FAIL_W = 4;
  // Failure index bits in the failure vector.
  localparam int unsigned F_3 = 0;
  localparam int unsigned F_6 = 1;
  localparam int unsigned F_47 = 2;
  localparam int unsigned F_8 = 3;
  // ==========================================================================
  // Interface mode
  // ==========================================================================
  typedef enum logic [2:0] {
    FTC_MODE_NORMAL = 3'b001,
    FTC_MODE_SLEEP = 3'b010,
    FTC_MODE_STANDBY = 3'b100
  } ftc_mode_e;
  localparam logic [1:0] MODE_CMD_NORMAL = 2'h0;
  localparam logic [1:0] MODE_CMD_SLEEP = 2'h1;
  localparam logic [1:0] MODE_CMD_STANDBY = 2'h2;
endpackage : ftc_pkg

// >>> hdl/ftc_persist.sv
// Persistence timer: a flag set only by conditions that last, cleared by lasting ones or at once by hold.
`timescale 1ns/1ps
`default_nettype none
module ftc_persist #(
  parameter int unsigned W = 18
) (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic hold_in,
  input wire logic cond_in,
  input wire logic [W-1:0] set_cycles_in,
  input wire logic [W-1:0] clr_cycles_in,
  output logic flag_out
);
  logic [W-1:0] cnt_reg;
  logic flag_reg;
  // A one-bit counter cannot hold any useful persistence time.
  if (W < 2) begin : g_bad_w
    $error("ftc_persist: W too small");
  end
  // Counts while the condition disagrees with the flag; restarts otherwise.
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in || hold_in) begin
      cnt_reg <= '0;
      flag_reg <= 1'b0;
    end else if (cond_in == flag_reg) begin
      cnt_reg <= '0;
    end else if (cnt_reg + W'(1) >= (flag_reg ? clr_cycles_in : set_cycles_in)) begin
      cnt_reg <= '0;
      flag_reg <= cond_in;
    end else begin
      cnt_reg <= cnt_reg + W'(1);
    end
  end
  assign flag_out = flag_reg;
endmodule : ftc_persist
`default_nettype wire

// >>> hdl/ftc_phy_ctrl.sv
// Top: transmit/receive mapping, failure handling, dominant guard and wake-up.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Bus driven dominant while transmit input is low, recessive when high.
// - Receive output low for dominant bus, high for recessive bus.
// - Dominant on either line counts as wake-up after the wake time.
// - Failure 3 set after 30 us persistence, cleared 160 us after it goes.
// - Failure 6 detected after 200 us, recovered after 200 us.
// - Failures 4 and 7 detected after 1.5 ms, recovered after 30 us.
// - Failures 3a and 8 detected after 1.7 ms, recovered after 1.5 ms.
// - Battery termination: failures 4 and 7 detect 1.2 ms, recover 1.92 ms.
// - Battery termination: failure 3 detects 3.84 ms, recovers 1.92 ms.
// - Battery termination: failures 3a and 8 detect 2.3 ms, recover 1.2 ms.
// - Separate line edge counts; difference of 3 sets the edge failure bit.
// - A further difference of 3 in either direction ends edge failure handling.
// - Transmit held dominant about 2 ms disables the transmitter.
// - Transmitter re-enabled after transmit input recessive for 30 us.
// - Mode is chosen by a command from the controlling processor.
// - Transceiver is unavailable in standby mode.
module ftc_phy_ctrl
(
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic txd_in,
  input wire logic canh_dom_in,
  input wire logic canl_dom_in,
  input wire logic [ftc_pkg::FAIL_W-1:0] fault_cond_in,
  input wire logic term_bat_in,
  input wire logic mode_wr_in,
  input wire logic [1:0] mode_cmd_in,
  output logic canh_drive_out,
  output logic canl_drive_out,
  output logic rxd_out,
  output logic wake_out,
  output logic [ftc_pkg::FAIL_W-1:0] fail_out,
  output logic edge_fail_out,
  output logic tx_disabled_out,
  output logic normal_out
);
  import ftc_pkg::*;
  // ==========================================================================
  // Elaboration checks
  // ==========================================================================
  // A count beyond the timer width would leave its timer unable to expire.
  if (FAIL_W != 4 || C_DF3_BAT >= 2 ** TMR_W || C_DR47_BAT >= 2 ** TMR_W
      || C_DF8_BAT >= 2 ** TMR_W || C_DF8 >= 2 ** TMR_W || C_TXD >= 2 ** TMR_W) begin : g_bad_cfg
    $error("ftc_phy_ctrl: timer width or failure count does not fit the logic");
  end
  // ==========================================================================
  // Mode
  // ==========================================================================
  ftc_mode_e mode_reg;
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      mode_reg <= FTC_MODE_SLEEP;
    end else if (mode_wr_in) begin
      case (mode_cmd_in)
        MODE_CMD_NORMAL: mode_reg <= FTC_MODE_NORMAL;
        MODE_CMD_SLEEP: mode_reg <= FTC_MODE_SLEEP;
        MODE_CMD_STANDBY: mode_reg <= FTC_MODE_STANDBY;
        // Code 3 has no meaning and leaves the mode as it is.
        default: mode_reg <= mode_reg;
      endcase
    end
  end
  logic is_normal;
  assign is_normal = (mode_reg == FTC_MODE_NORMAL);
  logic bus_dom;
  assign bus_dom = canh_dom_in | canl_dom_in;
  // ==========================================================================
  // Failure timers
  // ==========================================================================
  // Battery termination changes the timing of failures 3, 4/7 and 3a/8; failure 6 keeps one timing.
  logic [TMR_W-1:0] set_c [FAIL_W];
  logic [TMR_W-1:0] clr_c [FAIL_W];
  always_comb begin
    if (term_bat_in) begin
      set_c[F_3] = TMR_W'(C_DF3_BAT);
      clr_c[F_3] = TMR_W'(C_DR3_BAT);
      set_c[F_47] = TMR_W'(C_DF47_BAT);
      clr_c[F_47] = TMR_W'(C_DR47_BAT);
      set_c[F_8] = TMR_W'(C_DF8_BAT);
      clr_c[F_8] = TMR_W'(C_DR8_BAT);
    end else begin
      set_c[F_3] = TMR_W'(C_DF3);
      clr_c[F_3] = TMR_W'(C_DR3);
      set_c[F_47] = TMR_W'(C_DF47);
      clr_c[F_47] = TMR_W'(C_DR47);
      set_c[F_8] = TMR_W'(C_DF8);
      clr_c[F_8] = TMR_W'(C_DR8);
    end
    set_c[F_6] = TMR_W'(C_DF6);
    clr_c[F_6] = TMR_W'(C_DR6);
  end
  logic [FAIL_W-1:0] fail_w;
  genvar gi;
  generate
    for (gi = 0; gi < FAIL_W; gi++) begin : g_fail
      ftc_persist #(.W(TMR_W)) u_persist (
        .core_clk_in(core_clk_in),
        .resetn_in(resetn_in),
        .hold_in(!is_normal),
        .cond_in(fault_cond_in[gi]),
        .set_cycles_in(set_c[gi]),
        .clr_cycles_in(clr_c[gi]),
        .flag_out(fail_w[gi])
      );
    end
  endgenerate
  // ==========================================================================
  // Edge count difference for failures 1, 2, 5
  // ==========================================================================
  // Line samples reset to recessive, the idle level, so leaving reset makes no false edge.
  logic canh_d_reg;
  logic canl_d_reg;
  logic signed [3:0] diff_reg;
  logic edge_fail_reg;
  logic eh;
  logic el;
  assign eh = canh_dom_in ^ canh_d_reg;
  assign el = canl_dom_in ^ canl_d_reg;
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      canh_d_reg <= 1'b0;
      canl_d_reg <= 1'b0;
    end else begin
      canh_d_reg <= canh_dom_in;
      canl_d_reg <= canl_dom_in;
    end
  end
  // Difference restarts from zero at the threshold; reaching it flips the state.
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in || !is_normal) begin
      diff_reg <= '0;
      edge_fail_reg <= 1'b0;
    end else if (eh != el) begin
      if (!edge_fail_reg && diff_reg + (eh ? 4'sd1 : -4'sd1) == 4'sd3) begin
        edge_fail_reg <= 1'b1;
        diff_reg <= '0;
      end else if (!edge_fail_reg && diff_reg + (eh ? 4'sd1 : -4'sd1) == -4'sd3) begin
        edge_fail_reg <= 1'b1;
        diff_reg <= '0;
      end else if (edge_fail_reg && (diff_reg + (eh ? 4'sd1 : -4'sd1) == 4'sd3
                   || diff_reg + (eh ? 4'sd1 : -4'sd1) == -4'sd3)) begin
        edge_fail_reg <= 1'b0;
        diff_reg <= '0;
      end else begin
        diff_reg <= diff_reg + (eh ? 4'sd1 : -4'sd1);
      end
    end else if (eh && el) begin
      diff_reg <= diff_reg;
    end
  end
  // ==========================================================================
  // Transmit permanent-dominant guard
  // ==========================================================================
  logic [TMR_W-1:0] txd_cnt_reg;
  logic tx_dis_reg;
  // Counts while transmit sits at the level that moves the guard: low while enabled,
  // high while disabled; the other level restarts the count.
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      txd_cnt_reg <= '0;
      tx_dis_reg <= 1'b0;
    end else if (txd_in != tx_dis_reg) begin
      txd_cnt_reg <= '0;
    end else if (!tx_dis_reg && txd_cnt_reg + TMR_W'(1) >= TMR_W'(C_TXD)) begin
      tx_dis_reg <= 1'b1;
      txd_cnt_reg <= '0;
    end else if (tx_dis_reg && txd_cnt_reg + TMR_W'(1) >= TMR_W'(C_TXE)) begin
      tx_dis_reg <= 1'b0;
      txd_cnt_reg <= '0;
    end else begin
      txd_cnt_reg <= txd_cnt_reg + TMR_W'(1);
    end
  end
  // ==========================================================================
  // Wake-up filter
  // ==========================================================================
  logic [TMR_W-1:0] wake_cnt_reg;
  logic wake_reg;
  // The count holds once the wake time is reached, so the flag stays while the bus stays dominant.
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in || !bus_dom) begin
      wake_cnt_reg <= '0;
      wake_reg <= 1'b0;
    end else if (wake_cnt_reg + TMR_W'(1) >= TMR_W'(C_WAKE)) begin
      wake_reg <= 1'b1;
    end else begin
      wake_cnt_reg <= wake_cnt_reg + TMR_W'(1);
    end
  end
  // ==========================================================================
  // Driver and receiver
  // ==========================================================================
  // CANH stops driving while failure 4/7 is flagged, CANL while failure 3a/8 is, so the other line carries traffic alone.
  logic drv_en;
  assign drv_en = is_normal && !tx_dis_reg;
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      canh_drive_out <= 1'b0;
      canl_drive_out <= 1'b0;
      rxd_out <= 1'b1;
      wake_out <= 1'b0;
      fail_out <= '0;
      edge_fail_out <= 1'b0;
      tx_disabled_out <= 1'b0;
      normal_out <= 1'b0;
    end else begin
      canh_drive_out <= drv_en && !txd_in && !fail_w[F_47];
      canl_drive_out <= drv_en && !txd_in && !fail_w[F_8];
      rxd_out <= is_normal ? !bus_dom : 1'b1;
      wake_out <= wake_reg && !is_normal;
      fail_out <= fail_w;
      edge_fail_out <= edge_fail_reg;
      tx_disabled_out <= tx_dis_reg;
      normal_out <= is_normal;
    end
  end
endmodule : ftc_phy_ctrl
`default_nettype wire

// >>> test/ftc_phy_ctrl_sva.sv
// Checker: port-level properties of the CAN physical control block.
`timescale 1ns/1ps
`default_nettype none
module ftc_phy_ctrl_chk
(
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic txd_in,
  input wire logic canh_dom_in,
  input wire logic canl_dom_in,
  input wire logic [ftc_pkg::FAIL_W-1:0] fault_cond_in,
  input wire logic mode_wr_in,
  input wire logic [1:0] mode_cmd_in,
  input wire logic canh_drive_out,
  input wire logic canl_drive_out,
  input wire logic rxd_out,
  input wire logic wake_out,
  input wire logic [ftc_pkg::FAIL_W-1:0] fail_out,
  input wire logic edge_fail_out,
  input wire logic tx_disabled_out,
  input wire logic normal_out
);
  import ftc_pkg::*;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  logic [TMR_W-1:0] dom_run;
  logic [TMR_W-1:0] f3_on;
  logic [TMR_W-1:0] f3_off;
  always_ff @(posedge core_clk_in) begin
    dom_run <= (resetn_in && (canh_dom_in || canl_dom_in)) ? dom_run + TMR_W'(1) : '0;
  end
  always_ff @(posedge core_clk_in) begin
    f3_on <= (resetn_in && fault_cond_in[F_3]) ? f3_on + TMR_W'(1) : '0;
    f3_off <= (resetn_in && !fault_cond_in[F_3]) ? f3_off + TMR_W'(1) : '0;
  end
  logic [TMR_W-1:0] txd_low;
  logic [TMR_W-1:0] txd_high;
  always_ff @(posedge core_clk_in) begin
    txd_low <= (resetn_in && !txd_in) ? txd_low + TMR_W'(1) : '0;
    txd_high <= (resetn_in && txd_in) ? txd_high + TMR_W'(1) : '0;
  end
  sequence settled_normal;
    normal_out && !tx_disabled_out && !$past(tx_disabled_out) && !edge_fail_out &&
      fail_out == '0 && $past(fail_out) == '0;
  endsequence
  chk_tx_map: assert property (settled_normal |->
    canh_drive_out == !$past(txd_in) && canl_drive_out == !$past(txd_in))
    else $error("bus drive does not follow transmit input");
  chk_rx_map: assert property (normal_out && fail_out == '0 && !edge_fail_out &&
    $past(canh_dom_in) == $past(canl_dom_in) |-> rxd_out == !$past(canh_dom_in))
    else $error("receive output does not follow bus");
  chk_idle_out: assert property (!normal_out |->
    !canh_drive_out && !canl_drive_out && rxd_out)
    else $error("drivers or receive active outside normal mode");
  chk_fail_idle: assert property (!normal_out && !$past(normal_out) |->
    fail_out == '0 && !edge_fail_out)
    else $error("failure flags set outside normal mode");
  chk_mode_go: assert property (mode_wr_in && mode_cmd_in == MODE_CMD_NORMAL |->
    ##2 normal_out)
    else $error("normal command not taken");
  chk_cmd_ignored: assert property ((mode_wr_in && mode_cmd_in == 2'h3) ##1 !mode_wr_in
    |=> $stable(normal_out))
    else $error("unused mode command changed the mode");
  chk_wake_filter: assert property ($rose(wake_out) |-> $past(dom_run) >= C_WAKE)
    else $error("wake-up on a short dominant level");
  chk_f3_set: assert property (normal_out && $rose(fail_out[F_3]) |->
    $past(f3_on) >= C_DF3)
    else $error("failure 3 set too early");
  chk_f3_clear: assert property (normal_out && $past(normal_out) &&
    $fell(fail_out[F_3]) |-> $past(f3_off) >= C_DR3)
    else $error("failure 3 cleared too early");
  chk_tx_guard: assert property ($rose(tx_disabled_out) |-> $past(txd_low) >= C_TXD)
    else $error("transmitter disabled before the dominant time");
  chk_tx_release: assert property ($fell(tx_disabled_out) |-> $past(txd_high) >= C_TXE)
    else $error("transmitter enabled before the recessive time");
endmodule : ftc_phy_ctrl_chk
bind ftc_phy_ctrl ftc_phy_ctrl_chk chk_i (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
  .txd_in(txd_in), .canh_dom_in(canh_dom_in), .canl_dom_in(canl_dom_in),
  .fault_cond_in(fault_cond_in), .mode_wr_in(mode_wr_in), .mode_cmd_in(mode_cmd_in),
  .canh_drive_out(canh_drive_out), .canl_drive_out(canl_drive_out), .rxd_out(rxd_out),
  .wake_out(wake_out), .fail_out(fail_out), .edge_fail_out(edge_fail_out),
  .tx_disabled_out(tx_disabled_out), .normal_out(normal_out));
`default_nettype wire

// >>> test/ftc_bus_model.sv
// Bus model: other nodes, line faults and loop-back of the drivers.
`timescale 1ns/1ps
`default_nettype none
module ftc_bus_model (
  input wire logic canh_drive_in,
  input wire logic canl_drive_in,
  input wire logic other_dom_in,
  input wire logic canh_open_in,
  input wire logic canl_open_in,
  output logic canh_dom_out,
  output logic canl_dom_out
);
  // An open line never reads dominant, which unbalances the edge counts.
  assign canh_dom_out = !canh_open_in && (canh_drive_in || other_dom_in);
  assign canl_dom_out = !canl_open_in && (canl_drive_in || other_dom_in);
endmodule : ftc_bus_model
`default_nettype wire

// >>> test/fault_tolerant_can_phy_control_tb_top.sv
// Testbench: drives the CAN physical control block against a bus model.
`timescale 1ns/1ps
`default_nettype none
module fault_tolerant_can_phy_control_tb_top;
  import ftc_pkg::*;
  typedef struct packed {logic [10:0] exp_v; logic [10:0] mask_v;} ftc_note_s;
  logic core_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic txd_in = 1'b1;
  logic mode_wr_in = 1'b0;
  logic [1:0] mode_cmd_in = 2'h0;
  logic [FAIL_W-1:0] fault_cond_in = '0;
  logic other_dom = 1'b0;
  logic canh_open = 1'b0;
  logic canl_open = 1'b0;
  logic term_bat = 1'b0;
  logic canh_dom_in, canl_dom_in, canh_drive_out, canl_drive_out, rxd_out, wake_out;
  logic edge_fail_out, tx_disabled_out, normal_out;
  logic [FAIL_W-1:0] fail_out;
  int errors = 0;
  int samples_checked = 0;
  ftc_note_s notes[$];
  event check_ev;
  wire logic [10:0] obs = {canh_drive_out, canl_drive_out, rxd_out, wake_out, fail_out,
    edge_fail_out, tx_disabled_out, normal_out};
  initial forever #10 core_clk_in = ~core_clk_in;
  ftc_phy_ctrl dut (.core_clk_in(core_clk_in), .resetn_in(resetn_in), .txd_in(txd_in),
    .canh_dom_in(canh_dom_in), .canl_dom_in(canl_dom_in), .fault_cond_in(fault_cond_in),
    .term_bat_in(term_bat), .mode_wr_in(mode_wr_in), .mode_cmd_in(mode_cmd_in),
    .canh_drive_out(canh_drive_out), .canl_drive_out(canl_drive_out), .rxd_out(rxd_out),
    .wake_out(wake_out), .fail_out(fail_out), .edge_fail_out(edge_fail_out),
    .tx_disabled_out(tx_disabled_out), .normal_out(normal_out));
  ftc_bus_model bus (.canh_drive_in(canh_drive_out), .canl_drive_in(canl_drive_out),
    .other_dom_in(other_dom), .canh_open_in(canh_open), .canl_open_in(canl_open),
    .canh_dom_out(canh_dom_in), .canl_dom_out(canl_dom_in));
  // ==========================================================================
  // Checking
  // ==========================================================================
  always @(check_ev) begin
    ftc_note_s n;
    n = notes.pop_front();
    samples_checked++;
    if ((obs & n.mask_v) !== (n.exp_v & n.mask_v)) begin
      errors++;
      $display("wrong value outputs expected %h seen %h", n.exp_v & n.mask_v, obs & n.mask_v);
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // ==========================================================================
  // Stimulus
  // ==========================================================================
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask : cyc
  task automatic note(input logic [10:0] e, input logic [10:0] m);
    notes.push_back('{e, m});
    -> check_ev;
    #1;
  endtask : note
  task automatic set_mode(input logic [1:0] c);
    mode_cmd_in = c;
    mode_wr_in = 1'b1;
    cyc(1);
    mode_wr_in = 1'b0;
    cyc(3);
  endtask : set_mode
  task automatic persist(input int i, input int s, input int c);
    logic [10:0] b;
    b = 11'(11'h8 << i);
    fault_cond_in[i] = 1'b1;
    cyc(s - 50);
    fault_cond_in[i] = 1'b0;
    cyc(5);
    note('0, b);
    fault_cond_in[i] = 1'b1;
    cyc(s + 20);
    note(11'h7ff, b);
    fault_cond_in[i] = 1'b0;
    cyc(c - 50);
    note(11'h7ff, b);
    cyc(80);
    note('0, b);
  endtask : persist
  task automatic pulses(input int n);
    repeat (n) begin
      txd_in = 1'b0;
      cyc(5);
      txd_in = 1'b1;
      cyc(5);
    end
  endtask : pulses
  initial begin
    cyc(100000);
    errors++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'h3b3a_5df7));
    cyc(3);
    resetn_in = 1'b1;
    cyc(1);
    note(11'h100, 11'h7ff);
    set_mode(2'h3);
    note('0, 11'h001);
    set_mode(MODE_CMD_NORMAL);
    note(11'h001, 11'h001);
    $display("test mode done");
    repeat (20) begin
      txd_in = 1'($urandom);
      cyc(3);
      note({~txd_in, ~txd_in, txd_in, 8'h01}, 11'h703);
    end
    txd_in = 1'b1;
    $display("test mapping done");
    persist(F_3, C_DF3, C_DR3);
    persist(F_6, C_DF6, C_DR6);
    term_bat = 1'b1;
    fault_cond_in = 4'hf;
    cyc(C_DF3 + 20);
    note('0, 11'h078);
    fault_cond_in = '0;
    term_bat = 1'b0;
    $display("test failure timers done");
    canl_open = 1'b1;
    pulses(2);
    note(11'h004, 11'h004);
    canl_open = 1'b0;
    canh_open = 1'b1;
    pulses(2);
    note('0, 11'h004);
    canh_open = 1'b0;
    $display("test edge count done");
    txd_in = 1'b0;
    set_mode(MODE_CMD_STANDBY);
    note(11'h100, 11'h703);
    txd_in = 1'b1;
    set_mode(MODE_CMD_SLEEP);
    note('0, 11'h67d);
    other_dom = 1'b1;
    cyc(C_WAKE - 100);
    other_dom = 1'b0;
    cyc(5);
    note('0, 11'h080);
    other_dom = 1'b1;
    cyc(C_WAKE + 20);
    note(11'h180, 11'h180);
    $display("test wake done");
    tally_and_finish();
  end
endmodule : fault_tolerant_can_phy_control_tb_top
`default_nettype wire
